//--- rtl/rcdes_defs.svh
// constants of the receive channel lock and link status block
`ifndef RCDES_DEFS_SVH
`define RCDES_DEFS_SVH

// channel count and configuration latch geometry
`define RCDES_CH 4
`define RCDES_CFG_NUM 16
`define RCDES_CFG_RST 8'h00
`define RCDES_CFG_RATE 0
`define RCDES_CFG_DIS 1
`define RCDES_CFG_AMP_HI 3
`define RCDES_CFG_AMP_LO 2

// timing counts, in received bits (one bit per clk)
`define RCDES_DENS_LIMIT 6'h3C
`define RCDES_REF_TIMEOUT 7'h40
`define RCDES_CHAR_LAST 4'h9
`define RCDES_CHAR_HALF 4'h5
`define RCDES_RT_LAST 3'h4
`define RCDES_RT_PHASE 3'h2
`define RCDES_RANGE_BAD 2'h3

// register offsets and reset values
`define RCDES_OFF_STATUS 8'h00
`define RCDES_OFF_MASK 8'h04
`define RCDES_OFF_LINK 8'h08
`define RCDES_OFF_CFGRD 8'h0C
`define RCDES_STATUS_RST 8'h00
`define RCDES_MASK_RST 8'h00

`endif

//--- rtl/rcdes_pkg.sv
// types of the receive channel lock and link status block
`include "rcdes_defs.svh"
package rcdes_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WRITE = 2'h1,
    PH_READ = 2'h3
  } rcdes_phase_type;

  typedef enum logic [1:0] {
    RANGE_LOW = 2'h0,
    RANGE_MID = 2'h1,
    RANGE_HIGH = 2'h2,
    RANGE_BAD = 2'h3
  } rcdes_range_type;

  typedef struct packed {
    logic [3:0] pri;
    logic [3:0] sec;
    logic [3:0] insel;
    logic [3:0] lrf;
    logic [3:0] trgRef;
    logic [3:0] rateOk;
    logic [3:0] ampOk;
    logic lqe;
    logic [3:0][1:0] rangeSel;
    logic wrStb;
    logic [3:0] wrAddr;
    logic [7:0] wrData;
  } rcdes_pins_type;

  typedef struct packed {
    logic [9:0] shift;
    logic [9:0] charOut;
    logic [3:0] bitCnt;
    logic rxClk;
    logic [2:0] rtCnt;
    logic rtClk;
    logic prevBit;
    logic [5:0] runLen;
    logic prevRef;
    logic [6:0] refCnt;
    logic fault;
  } rcdes_chan_type;

  typedef struct packed {
    rcdes_chan_type [3:0] chan;
    logic [7:0] status;
    logic [7:0] mask;
    rcdes_phase_type phase;
    logic [7:0] addr;
  } rcdes_state_type;

  typedef struct packed {
    logic [15:0][7:0] latch;
    logic prevStb;
  } rcdes_cfg_state_type;

endpackage : rcdes_pkg

//--- rtl/rcdes_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module rcdes_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rcdes_sync_state_type;

  rcdes_sync_state_type stateReg;
  rcdes_sync_state_type stateNext;

  // meta is read by stable only
  always_comb
  begin
    stateNext.meta = d;
    stateNext.stable = stateReg.meta;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  assign q = stateReg.stable;
endmodule : rcdes_sync

//--- rtl/rcdes_cfg_port.sv
// configuration latch write port
`timescale 1ns/1ps
module rcdes_cfg_port (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // synchronised write port
  input wire logic wrStb,
  input wire logic [3:0] wrAddr,
  input wire logic [7:0] wrData,
  // latch contents
  output logic [15:0][7:0] cfgLatch
);
  import rcdes_pkg::*;

  rcdes_cfg_state_type stateReg;
  rcdes_cfg_state_type stateNext;

  // byte taken on the rising edge of the strobe
  always_comb
  begin
    stateNext = stateReg;
    stateNext.prevStb = wrStb;
    if (wrStb && !stateReg.prevStb)
      stateNext.latch[wrAddr] = wrData;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stateReg.latch <= {`RCDES_CFG_NUM{`RCDES_CFG_RST}};
      stateReg.prevStb <= 1'b0;
    end
    else
      stateReg <= stateNext;
  end

  assign cfgLatch = stateReg.latch;
endmodule : rcdes_cfg_port

//--- rtl/rcdes_lock_status.sv
// receive channel lock decision, link status and clock generation
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rcdes_defs.svh"

// Functional notes
// - receive clock runs continuously at 1/20 or 1/10 bit rate by rate select
// - ten-bit outputs timed by a true and complement receive clock pair
// - retimer clock at receive clock rate (select 0) or twice it (select 1)
// - retimer clock phase against receive clock is not fixed
// - reset puts every state machine, counter and latch in a known state
// - device reset leaves the scan controller alone; reset it separately
// - qualifier high: amplitude, range and density all must pass to track data
// - density fails after 60 received bits without a transition
// - qualifier low: only the range check decides tracking
// - local reference forced low locks to training reference, fault low
// - local reference high recovers clock and data from selected input
// - long idle or floating inputs may briefly shift receive clock frequency
// - loop range from three-level select: low, mid, high baud bands
// - input select high picks primary input, low picks secondary
// - link fault low is OR of six fault conditions
// - host presents byte and address, pulses strobe; byte goes to latch
// - full rate: data on rising clock; half rate: on both edges
module rcdes_lock_status (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial inputs and channel pins
  input wire logic [3:0] primary_serial_in,
  input wire logic [3:0] secondary_serial_in,
  input wire logic [3:0] input_port_sel,
  input wire logic [3:0] local_ref_force,
  input wire logic [3:0] training_ref_clk,
  input wire logic [3:0][1:0] line_rate_range_sel,
  input wire logic lock_qualifier_en,
  // analog detector results
  input wire logic [3:0] rateInRange,
  input wire logic [3:0] amplitudeOk,
  // configuration write port
  input wire logic cfg_write_strobe,
  input wire logic [3:0] cfgAddr,
  input wire logic [7:0] cfgData,
  // receive outputs
  output logic [3:0][9:0] rx_char_out,
  output logic [3:0] rx_char_clk_out,
  output logic [3:0] rx_char_clk_out_n,
  output logic [3:0] retimer_clk_out,
  output logic [3:0] link_fault_n,
  output logic [3:0] recovery_loop_track,
  output rcdes_pkg::rcdes_range_type [3:0] recovery_loop_range,
  output logic [3:0][1:0] amplitude_trip_sel,
  // interrupt
  output logic irq
);
  import rcdes_pkg::*;

  // ****************************************
  // pin synchronisers and configuration
  // ****************************************
  rcdes_pins_type pinsRaw;
  rcdes_pins_type pinsS;
  logic [15:0][7:0] cfgLatch;

  assign pinsRaw.pri = primary_serial_in;
  assign pinsRaw.sec = secondary_serial_in;
  assign pinsRaw.insel = input_port_sel;
  assign pinsRaw.lrf = local_ref_force;
  assign pinsRaw.trgRef = training_ref_clk;
  assign pinsRaw.rateOk = rateInRange;
  assign pinsRaw.ampOk = amplitudeOk;
  assign pinsRaw.lqe = lock_qualifier_en;
  assign pinsRaw.rangeSel = line_rate_range_sel;
  assign pinsRaw.wrStb = cfg_write_strobe;
  assign pinsRaw.wrAddr = cfgAddr;
  assign pinsRaw.wrData = cfgData;

  // every pin is asynchronous to clk
  rcdes_sync #(
    .W($bits(rcdes_pins_type))
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d(pinsRaw),
    .q(pinsS)
  );

  // the scan controller has its own reset and is not in this block
  rcdes_cfg_port u_cfg (
    .clk(clk),
    .srst(srst),
    .wrStb(pinsS.wrStb),
    .wrAddr(pinsS.wrAddr),
    .wrData(pinsS.wrData),
    .cfgLatch(cfgLatch)
  );

  // ****************************************
  // per channel decisions
  // ****************************************
  rcdes_state_type stateReg;
  rcdes_state_type stateNext;
  logic [3:0] selBit;
  logic [3:0] densOk;
  logic [3:0] refOk;
  logic [3:0] rangeOk;
  logic [3:0] qualOk;
  logic [3:0] trackData;
  logic [3:0] faultNow;
  logic [3:0] rateHalf;
  logic [3:0] chanOff;

  genvar g;
  generate
    for (g = 0; g < `RCDES_CH; g++)
    begin : g_chan
      // each channel has its own copy of every decision
      assign selBit[g] = pinsS.insel[g] ? pinsS.pri[g] : pinsS.sec[g];
      assign densOk[g] = stateReg.chan[g].runLen < `RCDES_DENS_LIMIT;
      assign refOk[g] = stateReg.chan[g].refCnt < `RCDES_REF_TIMEOUT;
      assign rangeOk[g] = pinsS.rateOk[g]
        && (pinsS.rangeSel[g] != `RCDES_RANGE_BAD);
      assign qualOk[g] = pinsS.lqe
        ? (rangeOk[g] && pinsS.ampOk[g] && densOk[g])
        : rangeOk[g];
      assign trackData[g] = pinsS.lrf[g] && qualOk[g];
      assign rateHalf[g] = cfgLatch[g][`RCDES_CFG_RATE];
      assign chanOff[g] = cfgLatch[g][`RCDES_CFG_DIS];
      assign faultNow[g] = !rangeOk[g] || !pinsS.ampOk[g] || !densOk[g]
        || chanOff[g] || !pinsS.lrf[g] || !refOk[g];
      assign recovery_loop_range[g] =
        rcdes_range_type'(pinsS.rangeSel[g]);
      assign amplitude_trip_sel[g] =
        cfgLatch[g][`RCDES_CFG_AMP_HI:`RCDES_CFG_AMP_LO];
      assign rx_char_out[g] = stateReg.chan[g].charOut;
      assign rx_char_clk_out[g] = stateReg.chan[g].rxClk;
      assign rx_char_clk_out_n[g] = !stateReg.chan[g].rxClk;
      assign retimer_clk_out[g] = stateReg.chan[g].rtClk;
      assign link_fault_n[g] = !stateReg.chan[g].fault;
    end
  endgenerate

  assign recovery_loop_track = trackData;

  // ****************************************
  // next state
  // ****************************************
  logic busTake;
  logic [7:0] evSet;
  logic [7:0] evClr;

  assign busTake = hsel && hready && htrans[1];

  always_comb
  begin
    stateNext = stateReg;
    evSet = 8'h00;
    evClr = 8'h00;
    for (int i = 0; i < `RCDES_CH; i++)
    begin
      // bit counter frames one character per ten received bits
      if (stateReg.chan[i].bitCnt == `RCDES_CHAR_LAST)
      begin
        stateNext.chan[i].bitCnt = 4'h0;
        // data changes with the rising clock, or either edge at half rate
        stateNext.chan[i].charOut =
          {stateReg.chan[i].shift[8:0], trackData[i] && selBit[i]};
        if (rateHalf[i])
          stateNext.chan[i].rxClk = !stateReg.chan[i].rxClk;
      end
      else
        stateNext.chan[i].bitCnt = stateReg.chan[i].bitCnt + 4'h1;
      // while on the training reference no data is recovered
      stateNext.chan[i].shift =
        {stateReg.chan[i].shift[8:0], trackData[i] && selBit[i]};
      if (!rateHalf[i])
        stateNext.chan[i].rxClk =
          stateNext.chan[i].bitCnt < `RCDES_CHAR_HALF;
      // retimer always runs at the character rate: equal to the full rate
      // receive clock, twice the half rate one; own counter, no phase tie
      if (stateReg.chan[i].rtCnt == `RCDES_RT_LAST)
      begin
        stateNext.chan[i].rtCnt = 3'h0;
        stateNext.chan[i].rtClk = !stateReg.chan[i].rtClk;
      end
      else
        stateNext.chan[i].rtCnt = stateReg.chan[i].rtCnt + 3'h1;
      // run length of identical bits, saturating at the limit
      stateNext.chan[i].prevBit = selBit[i];
      if (selBit[i] != stateReg.chan[i].prevBit)
        stateNext.chan[i].runLen = 6'h00;
      else if (densOk[i])
        stateNext.chan[i].runLen = stateReg.chan[i].runLen + 6'h01;
      // training reference presence from its edges
      stateNext.chan[i].prevRef = pinsS.trgRef[i];
      if (pinsS.trgRef[i] != stateReg.chan[i].prevRef)
        stateNext.chan[i].refCnt = 7'h00;
      else if (refOk[i])
        stateNext.chan[i].refCnt = stateReg.chan[i].refCnt + 7'h01;
      stateNext.chan[i].fault = faultNow[i];
      // events: fault raised, density lost
      evSet[i] = faultNow[i] && !stateReg.chan[i].fault;
      evSet[i + 4] = densOk[i]
        && (stateNext.chan[i].runLen == `RCDES_DENS_LIMIT);
    end
    // bus data phase
    if (stateReg.phase == PH_WRITE && stateReg.addr == `RCDES_OFF_MASK)
      stateNext.mask = hwdata[7:0];
    if (stateReg.phase == PH_READ && stateReg.addr == `RCDES_OFF_STATUS)
      evClr = stateReg.status;
    // an event in the clearing cycle survives
    stateNext.status = (stateReg.status & ~evClr) | evSet;
    // bus address phase
    if (busTake)
    begin
      stateNext.phase = hwrite ? PH_WRITE : PH_READ;
      stateNext.addr = haddr[7:0];
    end
    else
      stateNext.phase = PH_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // known state for every counter and machine
      for (int i = 0; i < `RCDES_CH; i++)
      begin
        stateReg.chan[i] <= '0;
        stateReg.chan[i].bitCnt <= `RCDES_CHAR_LAST; // full first high phase
        stateReg.chan[i].rtCnt <= `RCDES_RT_PHASE;
        stateReg.chan[i].fault <= 1'b1;
      end
      stateReg.status <= `RCDES_STATUS_RST;
      stateReg.mask <= `RCDES_MASK_RST;
      stateReg.phase <= PH_IDLE;
      stateReg.addr <= 8'h00;
    end
    else
      stateReg <= stateNext;
  end

  // ****************************************
  // bus read data and interrupt
  // ****************************************
  // zero wait states: every transfer completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (stateReg.phase == PH_READ)
    begin
      case (stateReg.addr)
        `RCDES_OFF_STATUS: hrdata = {24'h000000, stateReg.status};
        `RCDES_OFF_MASK: hrdata = {24'h000000, stateReg.mask};
        `RCDES_OFF_LINK: hrdata = {16'h0000, densOk, refOk,
                                   ~link_fault_n, trackData};
        `RCDES_OFF_CFGRD: hrdata = {cfgLatch[3], cfgLatch[2],
                                    cfgLatch[1], cfgLatch[0]};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign irq = |(stateReg.status & stateReg.mask);

  // ****************************************
  // checks on channel 0, the configuration write port and the interrupt
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_force_fault;
    !pinsS.lrf[0] |=> !link_fault_n[0];
  endproperty
  a_force_fault: assert property (p_force_fault)
    else $error("forced reference without link fault");

  property p_dens_recover;
    (selBit[0] != stateReg.chan[0].prevBit) |=> densOk[0] ##1 1'b1;
  endproperty
  a_dens_recover: assert property (p_dens_recover)
    else $error("density not restored by a transition");

  property p_qual_amp;
    pinsS.lqe && !pinsS.ampOk[0] |-> !trackData[0];
  endproperty
  a_qual_amp: assert property (p_qual_amp)
    else $error("tracking data with low amplitude");

  property p_range_only;
    !pinsS.lqe && rangeOk[0] && pinsS.lrf[0] |-> trackData[0];
  endproperty
  a_range_only: assert property (p_range_only)
    else $error("range alone did not allow tracking");

  property p_full_rate;
    disable iff (srst || rateHalf[0])
    $rose(rx_char_clk_out[0]) && !rateHalf[0] && !chanOff[0]
      |-> rx_char_clk_out[0][*5] ##1 !rx_char_clk_out[0];
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("full rate clock high time wrong");

  property p_data_edge;
    !$stable(rx_char_out[0]) && !rateHalf[0] && $stable(rateHalf[0])
      |-> $rose(rx_char_clk_out[0]);
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("data changed off the rising clock");

  property p_retimer;
    $rose(retimer_clk_out[0]) |-> ##5 $fell(retimer_clk_out[0]);
  endproperty
  a_retimer: assert property (p_retimer)
    else $error("retimer half period wrong");

  property p_ref_absent;
    !refOk[0] |=> !link_fault_n[0];
  endproperty
  a_ref_absent: assert property (p_ref_absent)
    else $error("missing reference without link fault");

  property p_input_sel;
    trackData[0] && pinsS.insel[0] |=>
      stateReg.chan[0].shift[0] == $past(pinsS.pri[0]);
  endproperty
  a_input_sel: assert property (p_input_sel)
    else $error("primary input not recovered");

  property p_cfg_write;
    pinsS.wrStb && !$past(pinsS.wrStb)
      |=> cfgLatch[$past(pinsS.wrAddr)] == $past(pinsS.wrData);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration byte not latched");

  c_fault_fall: cover property ($fell(link_fault_n[0]));
  c_char: cover property (trackData[0] ##1 !$stable(rx_char_out[0]));
  c_irq: cover property ($rose(irq));
  c_cfg: cover property ($rose(pinsS.wrStb));
endmodule : rcdes_lock_status

//--- verification/rcdes_serializer_model.sv
// remote serializer model: serial streams and training reference clocks
`timescale 1ns/1ps
module rcdes_serializer_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench control
  input wire logic [3:0] holdLine,
  input wire logic [3:0] refStop,
  // link side
  output logic [3:0] priBits,
  output logic [3:0] secBits,
  output logic [3:0] refClk
);
  // primary and secondary words differ in weight, so no rotation matches
  localparam logic [9:0] PRI_PAT = 10'h3F0;
  localparam logic [9:0] SEC_PAT = 10'h00F;
  logic [3:0] phase;
  logic [1:0] refDiv;
  always @(posedge clk)
  begin
    if (srst)
    begin
      phase <= 4'h0;
      refDiv <= 2'h0;
      priBits <= 4'h0;
      secBits <= 4'h0;
      refClk <= 4'h0;
    end
    else
    begin
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
      refDiv <= refDiv + 2'h1;
      for (int i = 0; i < 4; i++)
      begin
        // a held line keeps its level: no transitions for the density check
        if (!holdLine[i])
        begin
          priBits[i] <= PRI_PAT[phase];
          secBits[i] <= SEC_PAT[phase];
        end
        // a stopped reference stands still, as an absent clock would
        if (!refStop[i] && refDiv == 2'h3)
          refClk[i] <= ~refClk[i];
      end
    end
  end
endmodule : rcdes_serializer_model

//--- verification/rx_channel_lock_and_link_status_test.sv
// self-checking bench of the receive lock and link status block
`timescale 1ns/1ps
module rx_channel_lock_and_link_status_test;
  import rcdes_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata, rd;
  logic [3:0] pri, sec, trg, holdLine = 4'h0, refStop = 4'h0;
  logic [3:0] insel = 4'h5, lrf = 4'hF, rateOk = 4'hF, ampOk = 4'hF;
  logic [3:0][1:0] rangeSel = {2'h3, 2'h2, 2'h1, 2'h0};
  logic lqe = 1'b1;
  logic cfgStb = 1'b0;
  logic [3:0] cfgAddr = 4'h0;
  logic [7:0] cfgData = 8'h00;
  logic [3:0][9:0] chars;
  logic [3:0] rxClk, rxClkN, rtClk, faultN, track;
  rcdes_range_type [3:0] range;
  logic [3:0][1:0] ampTrip;
  int errors = 0;
  int samplesChecked = 0;
  always #12.5 clk = ~clk;
  rcdes_serializer_model far_u (.clk(clk), .srst(srst),
    .holdLine(holdLine), .refStop(refStop), .priBits(pri),
    .secBits(sec), .refClk(trg));
  rcdes_lock_status dut_u (.clk(clk), .srst(srst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .primary_serial_in(pri),
    .secondary_serial_in(sec), .input_port_sel(insel),
    .local_ref_force(lrf), .training_ref_clk(trg),
    .line_rate_range_sel(rangeSel), .lock_qualifier_en(lqe),
    .rateInRange(rateOk), .amplitudeOk(ampOk),
    .cfg_write_strobe(cfgStb), .cfgAddr(cfgAddr), .cfgData(cfgData),
    .rx_char_out(chars), .rx_char_clk_out(rxClk),
    .rx_char_clk_out_n(rxClkN), .retimer_clk_out(rtClk),
    .link_fault_n(faultN), .recovery_loop_track(track),
    .recovery_loop_range(range), .amplitude_trip_sel(ampTrip), .irq(irq));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // no wait limit of its own: only the watchdog ends a stuck transfer
  task automatic waitReady;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
  endtask : waitReady
  // one single AHB-Lite word transfer; read data taken at the last edge
  task automatic ahb(input logic wr, input logic [31:0] a,
    input logic [31:0] wd);
    @(posedge clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask : ahb
  task automatic cfgWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cfgAddr <= a;
    cfgData <= d;
    cyc(4);
    cfgStb <= 1'b1;
    cyc(4);
    cfgStb <= 1'b0;
    cyc(4);
  endtask : cfgWrite
  function automatic logic isRot(input logic [9:0] v,
    input logic [9:0] p);
    logic [9:0] r;
    r = p;
    for (int i = 0; i < 10; i++)
    begin
      if (v === r)
        return 1'b1;
      r = {r[8:0], r[9]};
    end
    return 1'b0;
  endfunction : isRot
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    chk(faultN, 4'h0);
    chk(irq, 1'b0);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_track;
    cyc(100);
    chk(track, 4'h7);
    chk(faultN, 4'h7);
    for (int i = 0; i < 4; i++)
      chk(range[i], i);
    chk(isRot(chars[0], 10'h3F0), 1'b1);
    chk(isRot(chars[1], 10'h00F), 1'b1);
    insel <= 4'hA;
    cyc(30);
    chk(isRot(chars[0], 10'h00F), 1'b1);
    chk(isRot(chars[1], 10'h3F0), 1'b1);
  endtask : t_track
  task automatic t_density;
    ahb(1'b0, 32'h0, 32'h0);
    holdLine <= 4'h1;
    cyc(45);
    chk(faultN[0], 1'b1);
    cyc(30);
    chk(faultN[0], 1'b0);
    chk(track[0], 1'b0);
    chk(irq, 1'b0);
    ahb(1'b1, 32'h4, 32'h11);
    cyc(1);
    chk(irq, 1'b1);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd & 32'h11, 32'h11);
    cyc(1);
    chk(irq, 1'b0);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd & 32'h11, 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    holdLine <= 4'h0;
    cyc(30);
    chk(faultN[0], 1'b1);
  endtask : t_density
  task automatic t_force;
    lrf <= 4'hC;
    cyc(5);
    chk(faultN, 4'h4);
    chk(track, 4'h4);
    cyc(25);
    chk(chars[0], 10'h0);
    chk(chars[1], 10'h0);
    lrf <= 4'hF;
    amplitudeOkLow();
  endtask : t_force
  task automatic amplitudeOkLow;
    ampOk <= 4'hA;
    lqe <= 1'b0;
    cyc(5);
    chk(track, 4'h7);
    chk(faultN, 4'h2);
    lqe <= 1'b1;
    cyc(5);
    chk(track, 4'h2);
    ampOk <= 4'hF;
    refStop <= 4'h5;
    cyc(100);
    chk(faultN, 4'h2);
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd[11:8], 4'hA);
    refStop <= 4'h0;
    cyc(100);
    chk(faultN, 4'h7);
  endtask : amplitudeOkLow
  task automatic t_cfg;
    int nRx0, nRx1, nRt0, nRt1;
    logic [3:0] pRx, pRt;
    cfgWrite(4'h0, 8'h01);
    cfgWrite(4'h1, 8'h02);
    cfgWrite(4'h2, 8'h0C);
    ahb(1'b0, 32'hC, 32'h0);
    chk(rd, 32'h000C0201);
    chk(ampTrip[2], 2'h3);
    chk(faultN[1], 1'b0);
    chk(rxClkN ^ rxClk, 4'hF);
    // rising edges over 200 bits: ch0 at half rate, ch1 at full rate
    nRx0 = 0;
    nRx1 = 0;
    nRt0 = 0;
    nRt1 = 0;
    pRx = rxClk;
    pRt = rtClk;
    repeat (200)
    begin
      @(posedge clk);
      nRx0 += int'(rxClk[0] & ~pRx[0]);
      nRx1 += int'(rxClk[1] & ~pRx[1]);
      nRt0 += int'(rtClk[0] & ~pRt[0]);
      nRt1 += int'(rtClk[1] & ~pRt[1]);
      pRx = rxClk;
      pRt = rtClk;
    end
    chk(nRx0, 10);
    chk(nRx1, 20);
    chk(nRt0, 20);
    chk(nRt1, 20);
  endtask : t_cfg
  // ************************************************************
  // run
  // ************************************************************
  task automatic final_report;
    if (errors == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    cyc(4);
    srst <= 1'b0;
    t_reset();
    t_track();
    t_density();
    t_force();
    t_cfg();
    final_report();
  end
  initial
  begin
    #(25 * 20000);
    errors++;
    final_report();
  end
endmodule : rx_channel_lock_and_link_status_test
